// file: testbench/ssr_peer.sv
`timescale 1ns/10ps
module ssr_peer (
   input wire logic sclk_line,
   input wire logic pol,
   output logic sdata,
   output logic sclk_out
);
   logic q[$];
   initial begin
      sdata = 1'b0;
      sclk_out = 1'b0;
   end
   // next bit goes out on the leading edge so it is settled at the trailing one
   always @(sclk_line) begin
      if ((sclk_line ^ pol) && q.size() > 0) begin
         sdata = q.pop_front();
      end else if (!(sclk_line ^ pol) && q.size() == 0) begin
         // no pull on the line: released data flips, but only after a hold time
         sdata <= #300 ~sdata;
      end
   end
   task automatic load(input logic [8:0] c, input int n);
      for (int i = 0; i < n; i++) begin
         q.push_back(c[i]);
      end
   endtask
   task automatic flush();
      q.delete();
   endtask
   task automatic idle();
      sclk_out = pol;
   endtask
   // acting as master: exactly n clocks, phase unrelated to the system clock
   task automatic frame(input logic [8:0] c, input int n);
      load(c, n);
      #37;
      for (int i = 0; i < n; i++) begin
         sclk_out = ~pol;
         #400;
         sclk_out = pol;
         #400;
      end
   endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
   logic clk, rst, wr, rd, receive_flag, pol, sclk_q, peer_data, peer_sclk, sclk_wire, data_wire;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, v;
   ssr_pkg::ssr_pin_t dpin, cpin;
   int errors, checks_done, edges, cycles;
   assign sclk_wire = cpin.oe ? cpin.drive : peer_sclk;
   assign data_wire = dpin.oe ? dpin.drive : peer_data;
   ssr_receiver #(.HALF(4), .DEPTH(2)) i_dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .data_line_i(data_wire), .clk_line_i(sclk_wire),
      .data_line_pin(dpin), .shift_clk_line_pin(cpin), .receive_flag(receive_flag)
   );
   ssr_peer i_peer (.sclk_line(sclk_wire), .pol(pol), .sdata(peer_data), .sclk_out(peer_sclk));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // leading edges on the wire, and the hang limit
   always @(posedge clk) begin
      sclk_q <= sclk_wire ^ pol;
      if ((sclk_wire ^ pol) && !sclk_q) begin
         edges <= edges + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic wait_flag();
      for (int n = 0; n < 400 && receive_flag !== 1'b1; n++) begin
         @(posedge clk);
      end
      chk({7'h00, receive_flag}, 8'h01);
   endtask
   task automatic wait_edges(input int tgt);
      for (int n = 0; n < 400 && edges < tgt; n++) begin
         @(posedge clk);
      end
   endtask
   task automatic poll(input logic [7:0] m, input logic [7:0] x);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      for (int n = 0; n < 300 && (v & m) !== x; n++) begin
         rd_reg(ssr_pkg::ADDR_CTRL, v);
      end
      chk(v & m, x);
   endtask
   task automatic test_regs();
      chk({4'h0, cpin, dpin}, 8'h00);
      rd_reg(ssr_pkg::ADDR_BAUD, v);
      chk(v, 8'h40);
      wr_reg(ssr_pkg::ADDR_BAUD, 8'hFF);
      rd_reg(ssr_pkg::ADDR_BAUD, v);
      chk(v, 8'h5B);
      wr_reg(ssr_pkg::ADDR_BAUD, 8'h00);
      wr_reg(ssr_pkg::ADDR_MODE, 8'hFF);
      rd_reg(ssr_pkg::ADDR_MODE, v);
      chk(v, 8'h01);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h00);
      $display("test regs done");
   endtask
   task automatic test_single8();
      int e0;
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h80);
      i_peer.load(9'h0B4, 8);
      e0 = edges;
      wr_reg(ssr_pkg::ADDR_CTRL, 8'hA0);
      wait_flag();
      poll(8'hFF, 8'h80);
      chk(8'(edges - e0), 8'h08);
      chk({7'h00, dpin.oe}, 8'h00);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'hB4);
      chk({7'h00, receive_flag}, 8'h00);
      $display("test single8 done");
   endtask
   task automatic test_overrun9();
      logic [8:0] c[3];
      int e0;
      c = '{9'h1A5, 9'h05A, 9'h133};
      e0 = edges;
      for (int i = 0; i < 3; i++) begin
         i_peer.load(c[i], 9);
         wr_reg(ssr_pkg::ADDR_CTRL, 8'hE0);
         poll(8'h20, 8'h00);
      end
      chk(8'(edges - e0), 8'd27);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      chk(v, 8'hC3);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'hA5);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      chk(v, 8'hC0);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h5A);
      chk({7'h00, receive_flag}, 8'h00);
      $display("test overrun9 done");
   endtask
   task automatic test_cont();
      int e0;
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h80);
      i_peer.load(9'h011, 8);
      i_peer.load(9'h022, 8);
      i_peer.load(9'h033, 8);
      e0 = edges;
      wr_reg(ssr_pkg::ADDR_CTRL, 8'hB0);
      poll(8'h02, 8'h02);
      repeat (40) @(posedge clk);
      chk(8'(edges - e0), 8'd24);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      chk(v, 8'h92);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h11);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h22);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      chk(v, 8'h92);
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h80);
      rd_reg(ssr_pkg::ADDR_CTRL, v);
      chk(v, 8'h80);
      $display("test cont done");
   endtask
   task automatic test_cut();
      int e0;
      i_peer.load(9'h0FF, 8);
      e0 = edges;
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h90);
      wait_edges(e0 + 3);
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h80);
      repeat (40) @(posedge clk);
      chk(8'(edges - e0), 8'h03);
      chk({7'h00, receive_flag}, 8'h00);
      i_peer.flush();
      i_peer.load(9'h06B, 8);
      wr_reg(ssr_pkg::ADDR_CTRL, 8'hA0);
      wait_flag();
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h6B);
      $display("test cut done");
   endtask
   task automatic test_slave();
      wr_reg(ssr_pkg::ADDR_BAUD, 8'h10);
      wr_reg(ssr_pkg::ADDR_MODE, 8'h00);
      pol <= 1'b1;
      @(posedge clk);
      i_peer.idle();
      wr_reg(ssr_pkg::ADDR_CTRL, 8'h90);
      chk({6'h00, cpin.oe, dpin.oe}, 8'h00);
      i_peer.frame(9'h03C, 8);
      i_peer.frame(9'h0C3, 8);
      wait_flag();
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'h3C);
      rd_reg(ssr_pkg::ADDR_RDR, v);
      chk(v, 8'hC3);
      $display("test slave done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      pol = 1'b0;
      sclk_q = 1'b0;
      edges = 0;
      cycles = 0;
      errors = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_regs();
      test_single8();
      test_overrun9();
      test_cont();
      test_cut();
      test_slave();
      tally_and_finish();
   end
endmodule

// file: verilog/ssr_fifo.sv
`timescale 1ns/10ps
module ssr_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic empty,
   output logic full
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [CW-1:0] cnt_r;
   logic do_push;
   logic do_pop;

   assign empty = (cnt_r == '0);
   assign full = (cnt_r == CNT_FULL);
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   // an empty fifo shows zero so a stray read returns a defined value
   assign head = empty ? '0 : mem[rp_r];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wp_r] <= push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_push) begin
            wp_r <= (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
         end
         if (do_pop) begin
            rp_r <= (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (do_pop && !do_push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// file: verilog/ssr_pkg.sv
package ssr_pkg;

   // register index on the plain register port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_RDR = 2'h1;
   localparam logic [1:0] ADDR_BAUD = 2'h2;
   localparam logic [1:0] ADDR_MODE = 2'h3;

   localparam int DATA_W = 8;
   localparam int CHAR_W = 9;
   localparam int FIFO_DEPTH = 2;

   // index of the last bit of a character
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;

   // master shift clock: half a link period in system clocks, rounded down
   localparam int CLK_PERIOD_NS = 100;
   localparam int LINK_PERIOD_NS = 800;
   localparam int HALF_CYCLES = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef struct packed {
      logic port_enable;
      logic nine_bit_select;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic address_detect;
      logic framing_error;
      logic overrun_error_flag;
      logic ninth_received_bit;
   } ssr_ctrl_t;

   typedef struct packed {
      logic autobaud_overflow;
      logic rx_idle_flag;
      logic unused5;
      logic sync_clk_polarity;
      logic wide_rate_divider;
      logic unused2;
      logic wakeup_enable;
      logic autobaud_enable;
   } ssr_baud_t;

   typedef struct packed {
      logic [6:0] unused;
      logic master_select;
   } ssr_mode_t;

   typedef struct packed {
      logic drive;
      logic oe;
   } ssr_pin_t;

endpackage

// file: verilog/ssr_receiver.sv
// Contract
// - synchronous master receive leaves the data line driver off.
// - reception starts when single or continuous receive enable is set; a slave starts on continuous only.
// - single receive: one clock per data bit, then hardware clears single enable.
// - continuous receive: clocks run without pause until continuous enable clears or overrun sets.
// - clearing continuous mid character with single enable clear stops the clock and discards the partial.
// - both enables set: single clears after first character, continuous carries on.
// - data sampled on trailing shift clock edge into the shift register.
// - full character sets receive flag and enters the two-entry fifo.
// - data register shows low eight bits of oldest entry; flag while unread.
// - slave takes shift clock from the clock line, its driver off.
// - sender changes data on leading edge; one bit per clock cycle.
// - third character with fifo full sets overrun, fifo kept intact.
// - during overrun stored data readable, no new characters accepted.
// - overrun in single mode clears on a data register read.
// - overrun in continuous mode clears by clearing continuous or port enable.
// - nine-bit select shifts nine bits per character.
// - ninth bit field shows bit nine of the oldest unread character.
`timescale 1ns/10ps
module ssr_receiver #(
   parameter int HALF = ssr_pkg::HALF_CYCLES,
   parameter int DEPTH = ssr_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic data_line_i,
   input wire logic clk_line_i,
   output ssr_pkg::ssr_pin_t data_line_pin,
   output ssr_pkg::ssr_pin_t shift_clk_line_pin,
   output logic receive_flag
);
   localparam int HW = $clog2(HALF + 1);
   localparam logic [HW-1:0] HALF_LAST = HW'(HALF - 1);

   typedef enum logic [1:0] {SSR_IDLE, SSR_LOW, SSR_HIGH} ssr_state_t;

   ssr_state_t st_r;
   logic [HW-1:0] half_r;
   logic pen_r;
   logic nine_r;
   logic single_r;
   logic cont_r;
   logic adden_r;
   logic pol_r;
   logic wide_r;
   logic wake_r;
   logic autobaud_r;
   logic master_r;
   logic ovr_r;
   logic ovr_cont_r;
   logic [3:0] bit_cnt_r;
   logic [ssr_pkg::CHAR_W-1:0] shreg_r;
   logic clk_q_r;
   logic data_s;
   logic clk_s;
   logic [7:0] rdata_r;

   logic run_en;
   logic slave_run;
   logic half_done;
   logic trail_m;
   logic trail_s;
   logic trail;
   logic last_bit;
   logic char_done;
   logic [ssr_pkg::CHAR_W-1:0] char_word;
   logic [ssr_pkg::CHAR_W-1:0] head;
   logic fifo_empty;
   logic fifo_full;
   logic push;
   logic rd_rdr;
   logic wr_ctrl;
   logic rx_idle;
   ssr_pkg::ssr_ctrl_t ctrl_view;
   ssr_pkg::ssr_baud_t baud_view;
   ssr_pkg::ssr_mode_t mode_view;
   ssr_pkg::ssr_ctrl_t wr_ctrl_v;
   ssr_pkg::ssr_baud_t wr_baud_v;
   ssr_pkg::ssr_mode_t wr_mode_v;

   // pins come from another domain: two flops before any logic looks at them
   ssr_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({data_line_i, clk_line_i}),
      .q({data_s, clk_s})
   );

   assign wr_ctrl_v = wdata;
   assign wr_baud_v = wdata;
   assign wr_mode_v = wdata;
   assign wr_ctrl = wr && (addr == ssr_pkg::ADDR_CTRL);
   assign rd_rdr = rd && (addr == ssr_pkg::ADDR_RDR);

   // overrun freezes the receiver until it is cleared
   assign run_en = pen_r && master_r && (single_r || cont_r) && !ovr_r;
   // single enable has no meaning for a slave
   assign slave_run = pen_r && !master_r && cont_r && !ovr_r;

   assign half_done = (half_r == HALF_LAST);
   assign trail_m = run_en && (st_r == SSR_HIGH) && half_done;
   // the peer moves data on the leading edge, so it is settled at the trailing one
   assign trail_s = slave_run && (clk_q_r ^ pol_r) && !(clk_s ^ pol_r);
   assign trail = trail_m || trail_s;

   assign last_bit = bit_cnt_r == (nine_r ? ssr_pkg::LAST_BIT_9 : ssr_pkg::LAST_BIT_8);
   assign char_done = trail && last_bit;
   // lsb arrives first; the bit on the line now is the last one
   assign char_word = nine_r ? {data_s, shreg_r[8:1]} : {1'b0, data_s, shreg_r[8:2]};
   assign push = char_done && !fifo_full && !ovr_r;

   always_ff @(posedge clk) begin
      if (rst || !run_en) begin
         st_r <= SSR_IDLE;
         half_r <= '0;
      end else begin
         unique case (st_r)
            SSR_IDLE: begin
               st_r <= SSR_LOW;
               half_r <= '0;
            end
            SSR_LOW: begin
               if (half_done) begin
                  st_r <= SSR_HIGH;
                  half_r <= '0;
               end else begin
                  half_r <= half_r + 1'b1;
               end
            end
            SSR_HIGH: begin
               if (half_done) begin
                  // continuous keeps going with no idle gap between characters
                  st_r <= (last_bit && !cont_r) ? SSR_IDLE : SSR_LOW;
                  half_r <= '0;
               end else begin
                  half_r <= half_r + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         clk_q_r <= 1'b0;
      end else begin
         clk_q_r <= clk_s;
      end
   end

   // leaving a run mid character drops the partial bits
   always_ff @(posedge clk) begin
      if (rst || !(run_en || slave_run)) begin
         bit_cnt_r <= '0;
      end else if (trail) begin
         bit_cnt_r <= last_bit ? '0 : bit_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shreg_r <= '0;
      end else if (trail) begin
         shreg_r <= {data_s, shreg_r[8:1]};
      end
   end

   ssr_fifo #(
      .W(ssr_pkg::CHAR_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(!pen_r),
      .push(push),
      .push_data(char_word),
      .pop(rd_rdr),
      .head(head),
      .empty(fifo_empty),
      .full(fifo_full)
   );

   assign receive_flag = !fifo_empty;

   always_ff @(posedge clk) begin
      if (rst) begin
         pen_r <= 1'b0;
         nine_r <= 1'b0;
         cont_r <= 1'b0;
         adden_r <= 1'b0;
      end else if (wr_ctrl) begin
         pen_r <= wr_ctrl_v.port_enable;
         nine_r <= wr_ctrl_v.nine_bit_select;
         cont_r <= wr_ctrl_v.continuous_receive_enable;
         adden_r <= wr_ctrl_v.address_detect;
      end
   end

   // a software write in the completing cycle wins over the hardware clear
   always_ff @(posedge clk) begin
      if (rst) begin
         single_r <= 1'b0;
      end else if (wr_ctrl) begin
         single_r <= wr_ctrl_v.single_receive_enable;
      end else if (char_done) begin
         single_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pol_r <= 1'b0;
         wide_r <= 1'b0;
         wake_r <= 1'b0;
         autobaud_r <= 1'b0;
         master_r <= 1'b0;
      end else if (wr && (addr == ssr_pkg::ADDR_BAUD)) begin
         pol_r <= wr_baud_v.sync_clk_polarity;
         wide_r <= wr_baud_v.wide_rate_divider;
         wake_r <= wr_baud_v.wakeup_enable;
         autobaud_r <= wr_baud_v.autobaud_enable;
      end else if (wr && (addr == ssr_pkg::ADDR_MODE)) begin
         master_r <= wr_mode_v.master_select;
      end
   end

   // set and clear never meet: a character cannot finish while overrun holds
   always_ff @(posedge clk) begin
      if (rst || !pen_r) begin
         ovr_r <= 1'b0;
         ovr_cont_r <= 1'b0;
      end else if (!ovr_r && char_done && fifo_full) begin
         ovr_r <= 1'b1;
         ovr_cont_r <= cont_r;
      end else if (ovr_r && (ovr_cont_r ? !cont_r : rd_rdr)) begin
         ovr_r <= 1'b0;
      end
   end

   assign rx_idle = (st_r == SSR_IDLE) && (bit_cnt_r == '0);

   always_comb begin
      ctrl_view = ssr_pkg::RESET_BYTE;
      ctrl_view.port_enable = pen_r;
      ctrl_view.nine_bit_select = nine_r;
      ctrl_view.single_receive_enable = single_r;
      ctrl_view.continuous_receive_enable = cont_r;
      ctrl_view.address_detect = adden_r;
      ctrl_view.overrun_error_flag = ovr_r;
      ctrl_view.ninth_received_bit = head[8];
      baud_view = ssr_pkg::RESET_BYTE;
      baud_view.rx_idle_flag = rx_idle;
      baud_view.sync_clk_polarity = pol_r;
      baud_view.wide_rate_divider = wide_r;
      baud_view.wakeup_enable = wake_r;
      baud_view.autobaud_enable = autobaud_r;
      mode_view = ssr_pkg::RESET_BYTE;
      mode_view.master_select = master_r;
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst || !rd) begin
         rdata_r <= ssr_pkg::RESET_BYTE;
      end else begin
         unique case (addr)
            ssr_pkg::ADDR_CTRL: rdata_r <= ctrl_view;
            ssr_pkg::ADDR_RDR: rdata_r <= head[7:0];
            ssr_pkg::ADDR_BAUD: rdata_r <= baud_view;
            ssr_pkg::ADDR_MODE: rdata_r <= mode_view;
         endcase
      end
   end

   assign rdata = rdata_r;
   // receive only: the data line is never driven
   assign data_line_pin = '{drive: 1'b0, oe: 1'b0};
   assign shift_clk_line_pin = '{drive: (st_r == SSR_HIGH) ^ pol_r, oe: pen_r && master_r};

   // ---------------- checks ----------------
   localparam int START_MAX = 2;
   localparam int STOP_MAX = 1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_start;
      $rose(run_en);
   endsequence

   sequence s_done_full;
      char_done && fifo_full && !ovr_r;
   endsequence

   sequence s_done_single;
      char_done && !wr_ctrl;
   endsequence

   data_drv_off_a: assert property (!data_line_pin.oe)
      else $error("data line driven");

   slave_clk_off_a: assert property (!master_r |-> !shift_clk_line_pin.oe)
      else $error("clock line driven in slave mode");

   master_start_a: assert property (s_start |-> ##[1:START_MAX] st_r == SSR_LOW)
      else $error("master did not start");

   single_clear_a: assert property (s_done_single |=> !single_r)
      else $error("single enable not cleared");

   cont_keep_a: assert property (
      char_done && cont_r && !fifo_full && run_en && !wr_ctrl |=> st_r == SSR_LOW)
      else $error("continuous clock paused");

   abort_a: assert property (
      $fell(cont_r) && !single_r && master_r |-> ##[0:STOP_MAX]
         (st_r == SSR_IDLE && bit_cnt_r == '0))
      else $error("partial character not dropped");

   push_a: assert property (push |=> !fifo_empty && receive_flag)
      else $error("character not stored");

   overrun_set_a: assert property (s_done_full |=> ovr_r && fifo_full)
      else $error("overrun missed or fifo changed");

   // reads may drain the fifo during overrun; only pushes and shifts are barred
   ovr_hold_a: assert property (ovr_r && !rd_rdr && pen_r |=> $stable(head) && !trail)
      else $error("receiver ran during overrun");

   ovr_read_a: assert property (ovr_r && !ovr_cont_r && rd_rdr |=> !ovr_r)
      else $error("read did not clear overrun");

   ovr_cont_a: assert property (ovr_r && ovr_cont_r && rd_rdr && cont_r |=> ovr_r)
      else $error("continuous overrun cleared by read");

   nine_len_a: assert property (
      char_done |-> bit_cnt_r == (nine_r ? ssr_pkg::LAST_BIT_9 : ssr_pkg::LAST_BIT_8))
      else $error("wrong character length");
endmodule

// file: verilog/ssr_sync.sv
`timescale 1ns/10ps
module ssr_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
